// *** hdl/oms_mode_select.sv ***
// Operating-mode capture, mode register, debug monitor gating, map
// decode and multiplexed external bus sequencing on ports A and B.
// Assumes pins are asynchronous; port registers, debug commands and the
// internal bus request come from logic on ref_clk.
`default_nettype none
module oms_mode_select (
   input  wire logic        ref_clk,
   input  wire logic        srst,
   input  wire logic        debugModePin,
   input  wire logic        modeSelectBPin,
   input  wire logic        modeSelectAPin,
   input  wire logic [7:0]  portAIn,
   input  wire logic [7:0]  portBIn,
   output var  logic [7:0]  portAOut,
   output var  logic [7:0]  portAOe,
   output var  logic [7:0]  portBOut,
   output var  logic [7:0]  portBOe,
   output var  logic [7:0]  portAPinLevel,
   output var  logic [7:0]  portBPinLevel,
   input  wire logic [7:0]  portAData,
   input  wire logic [7:0]  portADirection,
   input  wire logic [7:0]  portBData,
   input  wire logic [7:0]  portBDirection,
   input  wire logic        modeWrEn,
   input  wire logic [7:0]  modeWrData,
   output var  logic [7:0]  modeRdData,
   output var  logic        modeCaptured,
   input  wire logic        busReq,
   input  wire logic        busWrite,
   input  wire logic        busWord,
   input  wire logic [15:0] busAddr,
   input  wire logic [15:0] busWrData,
   output var  logic        busBusy,
   output var  logic        busDone,
   output var  logic [15:0] busRdData,
   input  wire logic        debugEnableCmd,
   input  wire logic        debugActivateCmd,
   input  wire logic        debugExitCmd,
   output var  logic        debugEnabled,
   output var  logic        debugActive,
   output var  logic        cpuHalt,
   output var  logic        writeProtect,
   output var  logic        portAbInMap,
   output var  logic        portEInMap,
   output var  logic        clockStretch,
   output var  logic        internalVisible,
   output var  logic        busStopInWait
);
   import oms_pkg::*;

   oms_pin_if     pinBus ();
   oms_state_type st_r;
   oms_state_type st_nxt;
   oms_mode_type  pinMode;
   oms_mode_type  wrMode;
   logic          syncDbg;
   logic          syncB;
   logic          syncA;
   logic [7:0]    syncPortA;
   logic [7:0]    syncPortB;

   // All asynchronous pins pass the two-stage synchroniser
   assign pinBus.rawPins = {debugModePin, modeSelectBPin, modeSelectAPin, portAIn, portBIn};

   oms_sync u_sync (
      .ref_clk (ref_clk),
      .pins    (pinBus)
   );

   assign {syncDbg, syncB, syncA, syncPortA, syncPortB} = pinBus.syncPins;

   // Pin levels as a mode code; reserved code folds to peripheral
   always_comb begin
      pinMode = oms_mode_type'({syncDbg, syncB, syncA});
      if (pinMode == MODE_RESERVED) begin
         pinMode = MODE_PERIPH;
      end
   end

   // Requested mode from a software write
   assign wrMode = oms_mode_type'({modeWrData[MR_SPBAR], modeWrData[MR_SELB], modeWrData[MR_SELA]});

   // Next-state logic for the whole block
   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;

      // Latch the mode on the first edge after reset is released
      if (!st_r.captured) begin
         st_nxt.captured      = 1'b1;
         st_nxt.mode          = pinMode;
         st_nxt.strch         = 1'b1;
         st_nxt.vis           = omsIsSpecial(pinMode);
         st_nxt.bStop         = 1'b0;
         st_nxt.emuE          = omsIsSpecial(pinMode);
         st_nxt.anyWrite      = 1'b0;
         st_nxt.normalWritten = 1'b0;
         st_nxt.dbgEnabled    = (pinMode == MODE_SPC_SINGLE);
         st_nxt.dbgActive     = (pinMode == MODE_SPC_SINGLE);
      end else begin
         // Mode register write; absent in peripheral mode, so the mode
         // can only change there through reset
         if (modeWrEn && !omsIsPeriph(st_r.mode)) begin
            st_nxt.anyWrite = 1'b1;
            if (omsIsSpecial(st_r.mode)) begin
               // Special modes: first write ignored for most bits
               st_nxt.strch = modeWrData[MR_STRCH];
               if (st_r.anyWrite) begin
                  if (wrMode != MODE_PERIPH && wrMode != MODE_RESERVED) begin
                     st_nxt.mode = wrMode;
                  end
                  st_nxt.vis  = modeWrData[MR_VIS];
                  st_nxt.emuE = modeWrData[MR_EMUE];
               end
            end else begin
               // Normal modes: bus-stop bit anytime, the rest once
               st_nxt.bStop = modeWrData[MR_BSTOP];
               if (!st_r.normalWritten) begin
                  st_nxt.normalWritten = 1'b1;
                  if (wrMode == MODE_NRM_SINGLE || wrMode == MODE_NRM_NARROW ||
                      wrMode == MODE_NRM_WIDE) begin
                     st_nxt.mode = wrMode;
                  end
                  st_nxt.strch = modeWrData[MR_STRCH];
                  st_nxt.vis   = modeWrData[MR_VIS];
                  st_nxt.emuE  = modeWrData[MR_EMUE];
               end
            end
         end

         // Debug monitor: enable first, then activate; never in peripheral
         if (!omsIsPeriph(st_r.mode)) begin
            if (debugEnableCmd) begin
               st_nxt.dbgEnabled = 1'b1;
            end
            if (debugActivateCmd && st_r.dbgEnabled) begin
               st_nxt.dbgActive = 1'b1;
            end
            if (debugExitCmd) begin
               st_nxt.dbgActive = 1'b0;
            end
         end
      end

      // Stretch control must stay set while an external bus exists
      if (omsIsExpanded(st_nxt.mode)) begin
         st_nxt.strch = 1'b1;
      end

      // External bus sequencer
      unique case (st_r.bus)
         BUS_IDLE: begin
            // Requests only taken in expanded modes
            if (st_r.captured && busReq && omsIsExpanded(st_r.mode)) begin
               st_nxt.bus   = BUS_ADDR;
               st_nxt.addr  = busAddr;
               st_nxt.wdata = busWrData;
               st_nxt.wr    = busWrite;
               st_nxt.word  = busWord;
               st_nxt.busy  = 1'b1;
            end
         end
         BUS_ADDR, BUS_ADDR2: begin
            st_nxt.bus     = (st_r.bus == BUS_ADDR) ? BUS_DATA : BUS_DATA2;
            st_nxt.holdCnt = 2'h0;
         end
         BUS_DATA: begin
            st_nxt.holdCnt = st_r.holdCnt + 2'h1;
            if (st_r.holdCnt == BUS_DATA_CYCLES - 2'h1) begin
               if (!st_r.wr) begin
                  if (omsIsNarrow(st_r.mode)) begin
                     // Narrow: high byte of a word first, on port A
                     if (st_r.word) begin
                        st_nxt.rdata[15:8] = syncPortA;
                     end else begin
                        st_nxt.rdata = {8'h00, syncPortA};
                     end
                  end else if (st_r.word) begin
                     st_nxt.rdata = {syncPortA, syncPortB};
                  end else begin
                     st_nxt.rdata = {8'h00, st_r.addr[0] ? syncPortB : syncPortA};
                  end
               end
               if (omsIsNarrow(st_r.mode) && st_r.word) begin
                  st_nxt.bus  = BUS_ADDR2;
                  st_nxt.addr = st_r.addr + 16'h0001;
               end else begin
                  st_nxt.bus  = BUS_IDLE;
                  st_nxt.busy = 1'b0;
                  st_nxt.done = 1'b1;
               end
            end
         end
         BUS_DATA2: begin
            st_nxt.holdCnt = st_r.holdCnt + 2'h1;
            if (st_r.holdCnt == BUS_DATA_CYCLES - 2'h1) begin
               if (!st_r.wr) begin
                  st_nxt.rdata[7:0] = syncPortA;
               end
               st_nxt.bus  = BUS_IDLE;
               st_nxt.busy = 1'b0;
               st_nxt.done = 1'b1;
            end
         end
         default: begin
            st_nxt.bus  = BUS_IDLE;
            st_nxt.busy = 1'b0;
         end
      endcase

      // Pin drive, computed from the next state so the pins are flops
      st_nxt.aOut = 8'h00;
      st_nxt.bOut = 8'h00;
      st_nxt.aOe  = 8'h00;
      st_nxt.bOe  = 8'h00;
      if (!st_nxt.captured) begin
         st_nxt.aOe = 8'h00;
      end else if (omsIsSingle(st_nxt.mode)) begin
         // Ports are plain I/O; no bus pins exist here
         st_nxt.aOut = portAData;
         st_nxt.aOe  = portADirection;
         st_nxt.bOut = portBData;
         st_nxt.bOe  = portBDirection;
      end else if (omsIsPeriph(st_nxt.mode)) begin
         // External master owns the bus; stay off the pins
         st_nxt.aOe = 8'h00;
      end else if (st_nxt.bus == BUS_ADDR || st_nxt.bus == BUS_ADDR2) begin
         st_nxt.aOut = st_nxt.addr[15:8];
         st_nxt.bOut = st_nxt.addr[7:0];
         st_nxt.aOe  = 8'hFF;
         st_nxt.bOe  = 8'hFF;
      end else if (st_nxt.bus == BUS_DATA || st_nxt.bus == BUS_DATA2) begin
         if (omsIsNarrow(st_nxt.mode)) begin
            // Port B keeps the low address; port A carries the byte
            st_nxt.bOut = st_nxt.addr[7:0];
            st_nxt.bOe  = 8'hFF;
            if (st_nxt.word && st_nxt.bus == BUS_DATA) begin
               st_nxt.aOut = st_nxt.wdata[15:8];
            end else begin
               st_nxt.aOut = st_nxt.wdata[7:0];
            end
            st_nxt.aOe = {8{st_nxt.wr}};
         end else if (st_nxt.word) begin
            st_nxt.aOut = st_nxt.wdata[15:8];
            st_nxt.bOut = st_nxt.wdata[7:0];
            st_nxt.aOe  = {8{st_nxt.wr}};
            st_nxt.bOe  = {8{st_nxt.wr}};
         end else begin
            // Wide byte access uses the lane chosen by address bit 0
            st_nxt.aOut = st_nxt.wdata[7:0];
            st_nxt.bOut = st_nxt.wdata[7:0];
            st_nxt.aOe  = {8{st_nxt.wr && !st_nxt.addr[0]}};
            st_nxt.bOe  = {8{st_nxt.wr && st_nxt.addr[0]}};
         end
      end

      // Register readback and map decode
      st_nxt.modeRd = 8'h00;
      st_nxt.modeRd[MR_SPBAR] = st_nxt.mode[2];
      st_nxt.modeRd[MR_SELB]  = st_nxt.mode[1];
      st_nxt.modeRd[MR_SELA]  = st_nxt.mode[0];
      st_nxt.modeRd[MR_STRCH] = st_nxt.strch;
      st_nxt.modeRd[MR_VIS]   = st_nxt.vis;
      st_nxt.modeRd[MR_BSTOP] = st_nxt.bStop;
      st_nxt.modeRd[MR_EMUE]  = st_nxt.emuE;
      st_nxt.abInMap = st_nxt.captured && omsIsSingle(st_nxt.mode);
      st_nxt.eInMap  = st_nxt.captured && (omsIsSingle(st_nxt.mode) ||
                       (omsIsExpanded(st_nxt.mode) && !st_nxt.emuE));
      st_nxt.halt    = st_nxt.captured && omsIsPeriph(st_nxt.mode);
      st_nxt.protect = st_nxt.captured && !omsIsSpecial(st_nxt.mode);
   end

   // Single state register; reset holds mode capture pending
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_r <= STATE_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register and synchroniser flops
   assign portAOut        = st_r.aOut;
   assign portAOe         = st_r.aOe;
   assign portBOut        = st_r.bOut;
   assign portBOe         = st_r.bOe;
   assign portAPinLevel   = syncPortA;
   assign portBPinLevel   = syncPortB;
   assign modeRdData      = st_r.modeRd;
   assign modeCaptured    = st_r.captured;
   assign busBusy         = st_r.busy;
   assign busDone         = st_r.done;
   assign busRdData       = st_r.rdata;
   assign debugEnabled    = st_r.dbgEnabled;
   assign debugActive     = st_r.dbgActive;
   assign cpuHalt         = st_r.halt;
   assign writeProtect    = st_r.protect;
   assign portAbInMap     = st_r.abInMap;
   assign portEInMap      = st_r.eInMap;
   assign clockStretch    = st_r.strch;
   assign internalVisible = st_r.vis;
   assign busStopInWait   = st_r.bStop;
endmodule
`default_nettype wire

// *** hdl/oms_pkg.sv ***
// Constants, types and mode decoding for the operating-mode select block.
// Assumes one 50 MHz clock (ref_clk) and a synchronous active-high reset.
// Summary of operation
// - Debug and mode-select pin levels latch into mode bits at reset release.
// - Debug pin high gives normal single chip, expanded narrow or expanded wide.
// - Debug pin low gives special single chip, narrow, peripheral or wide.
// - Debug pin high with select code 1,0 is forced to peripheral mode.
// - Single-chip modes have no external bus; everything stays internal.
// - Single-chip modes hand port A and B pins to general-purpose I/O.
// - Expanded wide modes run ports A and B as 16-bit multiplexed bus.
// - Expanded narrow: A and B carry address, port A alone carries byte data.
// - Narrow word transfers go as two byte cycles, high byte first.
// - Second narrow byte cycle presents the address plus one automatically.
// - Special single chip makes debug monitor active straight out of reset.
// - Normal modes need a debug enable command, then an activate command.
// - Normal modes protect control bits; special modes allow wider writes.
// - Peripheral mode idles the processor; an external master drives the bus.
// - Mode bits report the current mode and allow only limited changes.
// - Expanded and peripheral modes drop port A/B data and direction registers.
// - Port E registers leave the map in peripheral, or expanded with emulate bit.
// - Reads of unimplemented locations are undefined.
// - Software writes never select peripheral or the reserved mode.
`default_nettype none
package oms_pkg;

   // Mode code is {special_mode_bar, select B, select A}
   typedef enum logic [2:0] {
      MODE_SPC_SINGLE = 3'b000,
      MODE_SPC_NARROW = 3'b001,
      MODE_PERIPH     = 3'b010,
      MODE_SPC_WIDE   = 3'b011,
      MODE_NRM_SINGLE = 3'b100,
      MODE_NRM_NARROW = 3'b101,
      MODE_RESERVED   = 3'b110,
      MODE_NRM_WIDE   = 3'b111
   } oms_mode_type;

   typedef enum logic [2:0] {
      BUS_IDLE  = 3'b000,
      BUS_ADDR  = 3'b001,
      BUS_DATA  = 3'b010,
      BUS_ADDR2 = 3'b011,
      BUS_DATA2 = 3'b100
   } oms_bus_state_type;

   // Mode register bit positions
   localparam int MR_SPBAR = 7;
   localparam int MR_SELB  = 6;
   localparam int MR_SELA  = 5;
   localparam int MR_STRCH = 4;
   localparam int MR_VIS   = 3;
   localparam int MR_BSTOP = 2;
   localparam int MR_EMUE  = 0;

   // Data phase length; covers the two-stage pin synchroniser latency
   localparam logic [1:0] BUS_DATA_CYCLES = 2'h3;
   localparam int         PIN_WIDTH       = 19;

   typedef struct packed {
      logic              captured;
      oms_mode_type      mode;
      logic              strch;
      logic              vis;
      logic              bStop;
      logic              emuE;
      logic              anyWrite;
      logic              normalWritten;
      logic              dbgEnabled;
      logic              dbgActive;
      oms_bus_state_type bus;
      logic [1:0]        holdCnt;
      logic [15:0]       addr;
      logic [15:0]       wdata;
      logic [15:0]       rdata;
      logic              wr;
      logic              word;
      logic              busy;
      logic              done;
      logic [7:0]        aOut;
      logic [7:0]        aOe;
      logic [7:0]        bOut;
      logic [7:0]        bOe;
      logic [7:0]        modeRd;
      logic              abInMap;
      logic              eInMap;
      logic              halt;
      logic              protect;
   } oms_state_type;

   localparam oms_state_type STATE_RESET = '0;

   function automatic logic omsIsSpecial(input oms_mode_type m);
      return !m[2];
   endfunction

   function automatic logic omsIsSingle(input oms_mode_type m);
      return m[1:0] == 2'h0;
   endfunction

   function automatic logic omsIsPeriph(input oms_mode_type m);
      return m == MODE_PERIPH;
   endfunction

   function automatic logic omsIsNarrow(input oms_mode_type m);
      return m[1:0] == 2'h1;
   endfunction

   function automatic logic omsIsExpanded(input oms_mode_type m);
      return !omsIsSingle(m) && !omsIsPeriph(m);
   endfunction

endpackage
`default_nettype wire

// *** hdl/oms_pin_if.sv ***
// Carrier between the top block and its pin synchroniser.
// Raw pin levels go in, two-stage synchronised copies come back.
`default_nettype none
interface oms_pin_if;
   logic [oms_pkg::PIN_WIDTH-1:0] rawPins;
   logic [oms_pkg::PIN_WIDTH-1:0] syncPins;

   modport sampler (input rawPins, output syncPins);
   modport user    (output rawPins, input syncPins);
endinterface
`default_nettype wire

// *** hdl/oms_sync.sv ***
// Two flip-flop synchroniser for every asynchronous pin of the block.
// Assumes the pins may change at any time relative to ref_clk.
`default_nettype none
module oms_sync (
   input wire logic         ref_clk,
   oms_pin_if.sampler       pins
);
   import oms_pkg::*;

   typedef struct packed {
      logic [PIN_WIDTH-1:0] stage1;
      logic [PIN_WIDTH-1:0] stage2;
   } oms_sync_state_type;

   oms_sync_state_type syncState_r;
   oms_sync_state_type syncState_nxt;

   // No reset: mode pins must be sampled while reset is still held
   always_comb begin
      syncState_nxt.stage1 = pins.rawPins;
      syncState_nxt.stage2 = syncState_r.stage1;
   end

   always_ff @(posedge ref_clk) begin
      syncState_r <= syncState_nxt;
   end

   assign pins.syncPins = syncState_r.stage2;
endmodule
`default_nettype wire

// *** dv/oms_mode_select_asserts.sv ***
// Concurrent checks on the ports of the mode select top module.
// Assumes one clock, ref_clk, and a synchronous active-high srst.
`default_nettype none
module oms_mode_select_asserts (
   input wire logic        ref_clk,
   input wire logic        srst,
   input wire logic [7:0]  portAOut,
   input wire logic [7:0]  portAOe,
   input wire logic [7:0]  portBOut,
   input wire logic [7:0]  portBOe,
   input wire logic [7:0]  portAData,
   input wire logic [7:0]  portADirection,
   input wire logic        modeWrEn,
   input wire logic [7:0]  modeRdData,
   input wire logic        modeCaptured,
   input wire logic        busWord,
   input wire logic [15:0] busAddr,
   input wire logic        busBusy,
   input wire logic        busDone,
   input wire logic        debugActivateCmd,
   input wire logic        debugEnabled,
   input wire logic        debugActive,
   input wire logic        cpuHalt,
   input wire logic        portAbInMap,
   input wire logic        portEInMap
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   // Bus half: one address and three data cycles
   sequence sHalf; busBusy [*4]; endsequence
   sequence sEnd; busDone && !busBusy; endsequence
   wire logic narrowMode = modeRdData[6:5] == 2'b01;

   a_capture_edge: assert property ($rose(modeCaptured) |-> $past(srst, 2))
      else $error("mode captured outside reset release");
   a_no_reserved: assert property (modeCaptured |-> modeRdData[7:5] != 3'b110)
      else $error("reserved mode code reported");
   a_spc_debug: assert property ($rose(modeCaptured) && modeRdData[7:5] == 3'b000 |-> debugEnabled && debugActive)
      else $error("special single chip without active debug");
   a_debug_order: assert property ($rose(debugActive) && $past(modeCaptured)
      |-> $past(debugEnabled) && $past(debugActivateCmd))
      else $error("debug active without enable and activate");
   a_ab_map: assert property (modeCaptured |-> portAbInMap == (modeRdData[6:5] == 2'b00))
      else $error("port A/B map flag wrong");
   a_e_map: assert property (modeCaptured
      |-> portEInMap == !(cpuHalt || (!portAbInMap && modeRdData[0])))
      else $error("port E map flag wrong");
   a_gpio_mirror: assert property (portAbInMap && $past(portAbInMap)
      |-> portAOut == $past(portAData) && portAOe == $past(portADirection))
      else $error("port A not mirroring its registers");
   a_single_nobus: assert property (portAbInMap |-> !busBusy && !busDone)
      else $error("bus cycle in single chip mode");
   a_addr_phase: assert property ($rose(busBusy)
      |-> portAOe == 8'hFF && portBOe == 8'hFF && {portAOut, portBOut} == $past(busAddr))
      else $error("address phase wrong");
   a_one_half: assert property ($rose(busBusy) && !(narrowMode && $past(busWord)) |-> sHalf ##1 sEnd)
      else $error("single bus cycle length wrong");
   a_two_halves: assert property ($rose(busBusy) && narrowMode && $past(busWord)
      |-> sHalf ##1 sHalf ##1 sEnd)
      else $error("narrow word not two byte cycles");
   a_addr_incr: assert property ($rose(busBusy) && narrowMode && $past(busWord)
      |-> ##4 {portAOut, portBOut} == 16'($past(busAddr, 5) + 16'h0001))
      else $error("second byte address not incremented");
   a_mode_hold: assert property ($past(modeCaptured) && !$past(modeWrEn) |-> $stable(modeRdData))
      else $error("mode bits changed without a write");
   a_periph_float: assert property (cpuHalt |-> portAOe == 8'h00 && portBOe == 8'h00)
      else $error("device drives pins in peripheral mode");
endmodule

bind oms_mode_select oms_mode_select_asserts u_chk (.*);
`default_nettype wire

// *** dv/oms_ext_mem.sv ***
// Behavioural external memory on the multiplexed port A/B bus.
// Assumes phases from busBusy: one address cycle, then three data cycles.
`default_nettype none
module oms_ext_mem (
   input wire logic       ref_clk,
   input wire logic       busBusy,
   input wire logic       narrow,
   input wire logic [7:0] portAOut,
   input wire logic [7:0] portAOe,
   input wire logic [7:0] portBOut,
   output var logic [7:0] extA,
   output var logic [7:0] extB
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:255];
   logic [1:0] phase;
   logic [7:0] addrLo;

   // Low address byte only, to keep the model small
   initial begin
      phase = 2'h0;
      extA = 8'h5A;
      extB = 8'hA5;
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3C;
   end

   // Released lines toggle while idle and in the last data cycle so stale data never looks valid
   always @(posedge ref_clk) begin
      if (busBusy && phase == 2'h0) begin
         addrLo <= portBOut;
         extA <= mem[portBOut];
         extB <= narrow ? ~extB : mem[8'(portBOut + 8'h01)];
      end else if (!busBusy || phase == 2'h3) begin
         extA <= ~extA;
         extB <= ~extB;
      end
      if (busBusy && phase == 2'h3 && portAOe == 8'hFF) begin
         mem[addrLo] <= portAOut;
         if (!narrow) mem[8'(addrLo + 8'h01)] <= portBOut;
      end
      phase <= busBusy ? 2'(phase + 2'h1) : 2'h0;
   end
endmodule
`default_nettype wire

// *** dv/oms_mode_select_tb_top.sv ***
// Self-checking bench for the operating-mode select block.
// Assumes the external memory model and the bound port checker.
`default_nettype none
module oms_mode_select_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk, srst, debugModePin, modeSelectBPin, modeSelectAPin, narrow;
   logic [7:0]  portAIn, portBIn, portAOut, portAOe, portBOut, portBOe, extA, extB, modeWrData, modeRdData;
   logic [7:0]  portAData, portADirection, portBData, portBDirection, portAPinLevel, portBPinLevel;
   logic        modeWrEn, modeCaptured, busReq, busWrite, busWord, busBusy, busDone, busStopInWait;
   logic [15:0] busAddr, busWrData, busRdData, wordA, wordB;
   logic        debugEnableCmd, debugActivateCmd, debugExitCmd, debugEnabled, debugActive;
   logic        cpuHalt, writeProtect, portAbInMap, portEInMap, clockStretch, internalVisible;
   int          miscompares, samples_checked;
   integer      seed;
   logic [16:0] expQ[$];

   // Wire level: whichever party has its enable up
   assign portAIn = (portAOe & portAOut) | (~portAOe & extA);
   assign portBIn = (portBOe & portBOut) | (~portBOe & extB);

   oms_mode_select dut (.*);
   oms_ext_mem ext (.ref_clk(ref_clk), .busBusy(busBusy), .narrow(narrow), .portAOut(portAOut),
      .portAOe(portAOe), .portBOut(portBOut), .extA(extA), .extB(extB));

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic print_verdict();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Inputs always move 1 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      step(1);
      s = 1'b0;
   endtask

   task automatic do_reset(input logic [2:0] pins);
      srst = 1'b1;
      {debugModePin, modeSelectBPin, modeSelectAPin} = pins;
      step(10);
      srst = 1'b0;
      step(1);
   endtask

   // Held until busy; d is write data or expected read
   task automatic bus_op(input logic wr, input logic [15:0] a, input logic [15:0] d);
      int k;
      {busReq, busWrite, busWord, busAddr, busWrData} = {1'b1, wr, 1'b1, a, d};
      expQ.push_back({!wr, d});
      for (k = 0; k < 20; k++) begin
         step(1);
         if (busBusy === 1'b1) busReq = 1'b0;
         if (busDone === 1'b1) break;
      end
      if (k == 20) begin
         miscompares++;
         print_verdict();
      end
   endtask

   // Takes the oldest note at each completed transfer
   always @(negedge ref_clk) begin
      logic [16:0] note;
      if (busDone === 1'b1) begin
         if (expQ.size() == 0) chk("spare done", 16'h0000, 16'h0001);
         else begin
            note = expQ.pop_front();
            if (note[16]) chk("read data", note[15:0], busRdData);
         end
      end
   end

   initial begin
      logic [2:0] code;
      logic       sp;
      seed = 32'ha7d0;
      {miscompares, samples_checked} = '0;
      {modeWrEn, modeWrData, busReq, busWrite, busWord, busAddr, busWrData, narrow} = '0;
      {debugEnableCmd, debugActivateCmd, debugExitCmd} = '0;
      {portAData, portADirection, portBData, portBDirection} = '0;
      // Every pin combination, reserved one included
      for (int p = 0; p < 8; p++) begin
         do_reset(3'(p));
         code = (p == 6) ? 3'b010 : 3'(p);
         sp = !code[2];
         chk("mode bits", {6'h00, 1'b1, sp, code, 1'b1, sp, 2'b00, sp},
             {6'h00, clockStretch, internalVisible, modeRdData});
         chk("captured", 16'h0001, {15'h0, modeCaptured});
         chk("map", {13'h0, code[1:0] == 2'b00, !(sp && code[1:0] != 2'b00), code == 3'b010},
             {13'h0, portAbInMap, portEInMap, cpuHalt});
         chk("debug", {14'h0, code == 3'b000, code == 3'b000}, {14'h0, debugEnabled, debugActive});
         chk("protect", {15'h0, code[2]}, {15'h0, writeProtect});
         if (code == 3'b010) chk("periph oe", 16'h0000, {portAOe, portBOe});
         if (code[1:0] == 2'b00) begin
            {portAData, portADirection, portBData, portBDirection} = $random(seed);
            busReq = 1'b1;
            step(1);
            busReq = 1'b0;
            step(2);
            chk("gpio a", {portAData, portADirection}, {portAOut, portAOe});
            chk("pin level", {portAData, portBData} & {portADirection, portBDirection},
                {portAPinLevel, portBPinLevel} & {portADirection, portBDirection});
            chk("gpio b", {portBData, portBDirection}, {portBOut, portBOe});
            chk("bus refused", 16'h0000, {15'h0, busBusy});
         end
      end
      // Normal wide: back-to-back word traffic
      do_reset(3'b111);
      wordA = 16'($random(seed));
      wordB = 16'($random(seed));
      bus_op(1'b1, 16'hA510, wordA);
      bus_op(1'b0, 16'hA510, wordA);
      bus_op(1'b1, 16'h5A12, wordB);
      bus_op(1'b0, 16'h5A12, wordB);
      // Activate needs enable first
      pulse(debugActivateCmd);
      step(1);
      chk("early activate", 16'h0000, {15'h0, debugActive});
      pulse(debugEnableCmd);
      pulse(debugActivateCmd);
      step(1);
      chk("activate", 16'h0001, {15'h0, debugActive});
      pulse(debugExitCmd);
      step(1);
      chk("exit", 16'h0000, {15'h0, debugActive});
      // Reserved code asked by software: mode stays wide
      modeWrData = 8'hC4;
      pulse(modeWrEn);
      step(1);
      chk("mode write", 16'h00F4, {8'h00, modeRdData});
      chk("bus stop", 16'h0001, {15'h0, busStopInWait});
      // Narrow: read wide mode's word, then own
      narrow = 1'b1;
      do_reset(3'b101);
      bus_op(1'b0, 16'hA510, wordA);
      bus_op(1'b1, 16'h3C20, wordB);
      bus_op(1'b0, 16'h3C20, wordB);
      step(2);
      print_verdict();
   end
endmodule
`default_nettype wire
